/* File: rtl/arbr_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants and carriers of the result buffer logic
// Assumes : one 25 mhz clock, all channels convert together
// Notes   : timing figures kept in ns, cycle counts derived from them
//////////////////////////////////////////////////////////////////////////////
package arbr_pkg;

    // channel layout
    localparam int ARBR_NCH    = 2;
    localparam int ARBR_WORD_W = 24;
    localparam int ARBR_FRAME_W = ARBR_NCH * ARBR_WORD_W;
    localparam int ARBR_CNT_W  = $clog2(ARBR_FRAME_W + 1);

    // clock and ready pin timing
    localparam int ARBR_CLK_NS        = 40;
    localparam int ARBR_BLIP_HIGH_NS  = 40;   // narrow high blip, level format
    localparam int ARBR_PULSE_LOW_NS  = 160;  // low pulse, pulse format
    localparam int ARBR_BLIP_CYC  =
        (ARBR_BLIP_HIGH_NS / ARBR_CLK_NS) < 1 ? 1
        : (ARBR_BLIP_HIGH_NS / ARBR_CLK_NS);
    localparam int ARBR_PULSE_CYC =
        (ARBR_PULSE_LOW_NS / ARBR_CLK_NS) < 1 ? 1
        : (ARBR_PULSE_LOW_NS / ARBR_CLK_NS);
    localparam int ARBR_TMR_W = 8;

    // ready format encodings
    localparam logic ARBR_FMT_LEVEL = 1'b0;
    localparam logic ARBR_FMT_PULSE = 1'b1;

    // pin synchroniser bit positions
    localparam int ARBR_PIN_SCLK = 0;
    localparam int ARBR_PIN_CS   = 1;
    localparam int ARBR_PIN_SYNC = 2;
    localparam int ARBR_NPIN     = 3;

    // converter side carrier
    typedef struct packed {
        logic                                    done;
        logic [ARBR_NCH-1:0][ARBR_WORD_W-1:0]    data;
    } arbr_conv_t;

    // serial pin carrier
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic sync_reset_n;
    } arbr_pins_t;

    // ready pin states
    typedef enum logic [1:0] {
        ARBR_PIN_HIGH  = 2'b00,
        ARBR_PIN_LOW   = 2'b01,
        ARBR_PIN_BLIP  = 2'b10,
        ARBR_PIN_PULSE = 2'b11
    } arbr_pin_state_t;

endpackage : arbr_pkg

/* File: rtl/arbr_sync2.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : two flip-flop synchroniser for asynchronous pins
// Assumes : inputs are slow levels compared to ref_clk
// Notes   : first stage is read only by the second stage
//////////////////////////////////////////////////////////////////////////////
module arbr_sync2 #(
    parameter int    W         = 1,
    parameter logic  RST_VAL   = 1'b1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    // both stages reset to the idle pin level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r   <= {W{RST_VAL}};
            sync_out <= {W{RST_VAL}};
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : arbr_sync2

/* File: rtl/arbr_stage_mem.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : per channel output buffer and one deep fifo stage
// Assumes : controls are mutually consistent, decided by the caller
// Notes   : each buffer holds exactly one result; read data are registers
//////////////////////////////////////////////////////////////////////////////
module arbr_stage_mem
    import arbr_pkg::*;
#(
    parameter int NCH = ARBR_NCH,
    parameter int W   = ARBR_WORD_W
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  clear,
    input  wire logic                  load_out,
    input  wire logic                  load_fifo,
    input  wire logic                  copy_fifo,
    input  wire logic [NCH-1:0][W-1:0] new_data,
    output logic      [NCH-1:0][W-1:0] out_q,
    output logic      [NCH-1:0][W-1:0] fifo_q
);

    // one pair of holding registers per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge ref_clk) begin
            if (rst || clear) begin
                out_q[c]  <= '0;
                fifo_q[c] <= '0;
            end else begin
                if (load_out) begin
                    out_q[c] <= new_data[c];
                end
                // fresh result wins over the copy of the older one
                if (load_fifo) begin
                    fifo_q[c] <= new_data[c];
                end else if (copy_fifo) begin
                    fifo_q[c] <= out_q[c];
                end
            end
        end
    end

endmodule : arbr_stage_mem

/* File: rtl/arbr_ready_logic.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : result buffering, serial shift-out and data ready signalling
// Assumes : conversions of all channels complete in the same cycle
// Notes   : sclk, cs_n and sync pins are sampled, not used as clocks
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - fifo stage already read: new result loads output buffer and fifo
// - reading a result already in both buffers changes neither buffer
// - new result while fifo unread: only output buffer updates
// - after a stale fifo read, copy output buffer into fifo stage
// - second new result while fifo unread: newest overwrites both buffers
// - level format: pin falls on new data, rises when all data shifted
// - pulse format: each new result that loads the fifo stage gives a short low pulse
// - level format, unread result: pin blips high before falling again
// - pulse format, unread result: that pulse is skipped
// - pulse format without reads: pin toggles at half conversion rate
// - data ready flag clears on a complete conversion data read unless a newer result is waiting in the output buffer or arrives in the same cycle
// - resync strobe clears both buffers and restarts conversions
// - level format catch-up: narrow high blip after first stale read
// - shifted out data always come from the fifo stage
// - every channel owns one output buffer and one fifo stage
module arbr_ready_logic
    import arbr_pkg::*;
#(
    parameter int BLIP_CYC  = ARBR_BLIP_CYC,
    parameter int PULSE_CYC = ARBR_PULSE_CYC
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    input  wire arbr_pkg::arbr_conv_t     conv_in,
    input  wire arbr_pkg::arbr_pins_t     pins_in,
    input  wire logic                     ready_signal_format,
    input  wire logic [arbr_pkg::ARBR_NCH-1:0] ch_enable,
    output logic                          data_ready_n_pin,
    output logic                          dout,
    output logic                          dout_oe,
    output logic                          data_ready_flag,
    output logic                          conv_restart
);
    import arbr_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // functions

    // number of bits in a frame of enabled channels
    function automatic logic [ARBR_CNT_W-1:0] frame_bits(
        input logic [ARBR_NCH-1:0] en
    );
        logic [ARBR_CNT_W-1:0] n;
        n = '0;
        for (int c = 0; c < ARBR_NCH; c++) begin
            if (en[c]) begin
                n = n + ARBR_CNT_W'(ARBR_WORD_W);
            end
        end
        return n;
    endfunction : frame_bits

    // packs enabled channel words msb first, channel 0 leading
    function automatic logic [ARBR_FRAME_W-1:0] pack_frame(
        input logic [ARBR_NCH-1:0][ARBR_WORD_W-1:0] d,
        input logic [ARBR_NCH-1:0]                 en
    );
        logic [ARBR_FRAME_W-1:0] f;
        f = '0;
        for (int c = ARBR_NCH - 1; c >= 0; c--) begin
            if (en[c]) begin
                f = {d[c], f[ARBR_FRAME_W-1:ARBR_WORD_W]};
            end
        end
        // each word enters at the top, so the frame is already left aligned
        return f;
    endfunction : pack_frame

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [ARBR_NPIN-1:0] pin_raw;
    logic [ARBR_NPIN-1:0] pin_s;
    logic                 sclk_q_r;
    logic                 cs_q_r;
    logic                 sync_q_r;

    assign pin_raw[ARBR_PIN_SCLK] = pins_in.sclk;
    assign pin_raw[ARBR_PIN_CS]   = pins_in.cs_n;
    assign pin_raw[ARBR_PIN_SYNC] = pins_in.sync_reset_n;

    arbr_sync2 #(
        .W       (ARBR_NPIN),
        .RST_VAL (1'b1)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    // previous synchronised levels for edge finding
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_q_r <= 1'b1;
            cs_q_r   <= 1'b1;
            sync_q_r <= 1'b1;
        end else begin
            sclk_q_r <= pin_s[ARBR_PIN_SCLK];
            cs_q_r   <= pin_s[ARBR_PIN_CS];
            sync_q_r <= pin_s[ARBR_PIN_SYNC];
        end
    end

    wire sclk_fall = sclk_q_r & ~pin_s[ARBR_PIN_SCLK];
    wire cs_fall   = cs_q_r & ~pin_s[ARBR_PIN_CS];
    wire cs_low    = ~pin_s[ARBR_PIN_CS];
    wire resync    = sync_q_r & ~pin_s[ARBR_PIN_SYNC];

    //////////////////////////////////////////////////////////////////////////
    // serial shift-out

    logic [ARBR_FRAME_W-1:0]             shreg_r;
    logic [ARBR_CNT_W-1:0]               bit_cnt_r;
    logic                                active_r;
    logic                                read_done_r;
    logic [ARBR_NCH-1:0][ARBR_WORD_W-1:0] fifo_q;
    logic [ARBR_NCH-1:0][ARBR_WORD_W-1:0] out_q;

    wire [ARBR_CNT_W-1:0] bits_need = frame_bits(ch_enable);
    wire [ARBR_CNT_W-1:0] bit_inc   = bit_cnt_r + ARBR_CNT_W'(1);
    wire                  shift_now = active_r & cs_low & sclk_fall;
    wire                  last_bit  = shift_now & (bit_inc == bits_need);
    // fifo words as the host will see them, named so bits can be picked
    wire [ARBR_FRAME_W-1:0] frame_now = pack_frame(fifo_q, ch_enable);

    // host samples on sclk falling edge, next bit presented then;
    // a frame cut short by cs_n rising leaves the result unread
    always_ff @(posedge ref_clk) begin
        if (rst || resync) begin
            shreg_r     <= '0;
            bit_cnt_r   <= '0;
            active_r    <= 1'b0;
            read_done_r <= 1'b0;
        end else begin
            read_done_r <= last_bit;
            if (cs_fall) begin
                shreg_r   <= frame_now;
                bit_cnt_r <= '0;
                active_r  <= (bits_need != '0);
            end else if (!cs_low || last_bit) begin
                active_r  <= 1'b0;
            end
            if (shift_now) begin
                shreg_r   <= shreg_r << 1;
                bit_cnt_r <= bit_inc;
            end
        end
    end

    // data pin driven only while selected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dout    <= 1'b0;
            dout_oe <= 1'b0;
        end else begin
            dout_oe <= cs_low;
            if (cs_fall) begin
                dout <= frame_now[ARBR_FRAME_W-1];
            end else if (shift_now) begin
                dout <= shreg_r[ARBR_FRAME_W-2];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // buffer update decisions

    logic unread_r;    // fifo stage holds a result not yet read
    logic pending_r;   // output buffer newer than fifo stage

    // a read finishing with a conversion counts before the conversion
    wire conv       = conv_in.done & ~resync;
    wire rd         = read_done_r & ~resync;
    wire unread_eff = unread_r & ~rd;
    wire fresh_conv = conv & (~unread_eff | pending_r);
    wire out_only   = conv & unread_eff & ~pending_r;
    wire copy_old   = rd & pending_r & ~conv;
    wire fresh      = fresh_conv | copy_old;

    arbr_stage_mem #(
        .NCH (ARBR_NCH),
        .W   (ARBR_WORD_W)
    ) u_mem (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .clear     (resync),
        .load_out  (conv),
        .load_fifo (fresh_conv),
        .copy_fifo (copy_old),
        .new_data  (conv_in.data),
        .out_q     (out_q),
        .fifo_q    (fifo_q)
    );

    // a plain reread leaves both buffers alone
    always_ff @(posedge ref_clk) begin
        if (rst || resync) begin
            unread_r  <= 1'b0;
            pending_r <= 1'b0;
        end else begin
            if (fresh_conv || copy_old) begin
                pending_r <= 1'b0;
            end else if (out_only) begin
                pending_r <= 1'b1;
            end
            if (fresh) begin
                unread_r <= 1'b1;
            end else if (rd) begin
                unread_r <= 1'b0;
            end
        end
    end

    // status flag: a fresh result in the same cycle beats the clear
    always_ff @(posedge ref_clk) begin
        if (rst || resync) begin
            data_ready_flag <= 1'b0;
        end else if (fresh) begin
            data_ready_flag <= 1'b1;
        end else if (rd) begin
            data_ready_flag <= 1'b0;
        end
    end

    // restart strobe towards the modulators
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conv_restart <= 1'b0;
        end else begin
            conv_restart <= resync;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // ready pin sequencing

    arbr_pin_state_t       pin_st_r;
    arbr_pin_state_t       pin_st_nxt;
    logic [ARBR_TMR_W-1:0] tmr_r;
    logic [ARBR_TMR_W-1:0] tmr_nxt;

    wire tmr_done   = (tmr_r == '0);
    wire level_fmt  = (ready_signal_format == ARBR_FMT_LEVEL);
    wire [ARBR_TMR_W-1:0] blip_len  = ARBR_TMR_W'(BLIP_CYC - 1);
    wire [ARBR_TMR_W-1:0] pulse_len = ARBR_TMR_W'(PULSE_CYC - 1);

    // pulse format only pulses on conversions that reach the fifo, so a
    // skipped update also skips its pulse
    always_comb begin
        pin_st_nxt = pin_st_r;
        tmr_nxt    = tmr_done ? tmr_r : tmr_r - ARBR_TMR_W'(1);
        if (level_fmt) begin
            case (pin_st_r)
                ARBR_PIN_HIGH: begin
                    if (fresh || out_only) begin
                        pin_st_nxt = ARBR_PIN_LOW;
                    end
                end
                ARBR_PIN_LOW: begin
                    if (fresh || out_only) begin
                        pin_st_nxt = ARBR_PIN_BLIP;
                        tmr_nxt    = blip_len;
                    end else if (rd) begin
                        pin_st_nxt = ARBR_PIN_HIGH;
                    end
                end
                ARBR_PIN_BLIP: begin
                    if (tmr_done) begin
                        pin_st_nxt = ARBR_PIN_LOW;
                    end
                end
                default: begin
                    pin_st_nxt = ARBR_PIN_HIGH;
                end
            endcase
        end else begin
            case (pin_st_r)
                ARBR_PIN_PULSE: begin
                    if (tmr_done) begin
                        pin_st_nxt = ARBR_PIN_HIGH;
                    end
                end
                default: begin
                    pin_st_nxt = ARBR_PIN_HIGH;
                    if (fresh_conv) begin
                        pin_st_nxt = ARBR_PIN_PULSE;
                        tmr_nxt    = pulse_len;
                    end
                end
            endcase
        end
    end

    wire pin_low_nxt = (pin_st_nxt == ARBR_PIN_LOW) ||
                       (pin_st_nxt == ARBR_PIN_PULSE);

    // pin idles high after reset and after a resync
    always_ff @(posedge ref_clk) begin
        if (rst || resync) begin
            pin_st_r         <= ARBR_PIN_HIGH;
            tmr_r            <= '0;
            data_ready_n_pin <= 1'b1;
        end else begin
            pin_st_r         <= pin_st_nxt;
            tmr_r            <= tmr_nxt;
            data_ready_n_pin <= ~pin_low_nxt;
        end
    end

endmodule : arbr_ready_logic

/* File: tb/arbr_ready_logic_monitor.sv */
// Purpose : port level checks of the result buffer ready logic
// Assumes : one ref_clk domain, synchronous active high reset
// Notes   : stimulus keeps conversions clear of resync strobes
module arbr_ready_logic_monitor
#(
    parameter int BLIP_CYC  = arbr_pkg::ARBR_BLIP_CYC,
    parameter int PULSE_CYC = arbr_pkg::ARBR_PULSE_CYC
) (
    input wire logic                          ref_clk,
    input wire logic                          rst,
    input wire arbr_pkg::arbr_conv_t          conv_in,
    input wire arbr_pkg::arbr_pins_t          pins_in,
    input wire logic                          ready_signal_format,
    input wire logic [arbr_pkg::ARBR_NCH-1:0] ch_enable,
    input wire logic                          data_ready_n_pin,
    input wire logic                          dout,
    input wire logic                          dout_oe,
    input wire logic                          data_ready_flag,
    input wire logic                          conv_restart
);
    timeunit 1ns;
    timeprecision 1ns;
    import arbr_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // conversion to flag and pin; repeat count 4 is the PULSE_CYC default
    a_conv_sets_flag: assert property (
        conv_in.done && pins_in.sync_reset_n |=> data_ready_flag)
        else $error("flag not set after conversion");
    a_level_falls: assert property (
        ready_signal_format == ARBR_FMT_LEVEL && conv_in.done
        && !data_ready_flag && pins_in.sync_reset_n |=> !data_ready_n_pin)
        else $error("ready pin did not fall");
    a_level_idle: assert property (
        ready_signal_format == ARBR_FMT_LEVEL && !data_ready_flag
        |-> data_ready_n_pin)
        else $error("ready pin low with nothing unread");
    a_blip_narrow: assert property (
        ready_signal_format == ARBR_FMT_LEVEL && $rose(data_ready_n_pin)
        && data_ready_flag |=> !data_ready_n_pin)
        else $error("blip not one cycle");
    a_pulse_shape: assert property (
        ready_signal_format == ARBR_FMT_PULSE && conv_in.done
        && !data_ready_flag && pins_in.sync_reset_n
        |=> !data_ready_n_pin [*4] ##1 data_ready_n_pin)
        else $error("pulse shape wrong");
    a_flag_fall: assert property (
        $fell(data_ready_flag)
        |-> !pins_in.sync_reset_n || !$past(pins_in.cs_n, 2))
        else $error("flag cleared without read");
    a_restart_due: assert property (
        $fell(pins_in.sync_reset_n) |-> ##[2:6] conv_restart)
        else $error("no restart after resync");
    a_restart_once: assert property (
        conv_restart |=> !conv_restart)
        else $error("restart longer than a cycle");
    a_restart_clean: assert property (
        conv_restart |-> !data_ready_flag && data_ready_n_pin)
        else $error("resync left state");
    a_oe_on: assert property (
        $fell(pins_in.cs_n) |-> ##[2:5] dout_oe)
        else $error("dout not enabled");
    a_oe_off: assert property (
        $rose(pins_in.cs_n) |-> ##[2:5] !dout_oe)
        else $error("dout not released");
endmodule : arbr_ready_logic_monitor

bind arbr_ready_logic arbr_ready_logic_monitor #(
    .BLIP_CYC(BLIP_CYC), .PULSE_CYC(PULSE_CYC)
) u_mon (
    .ref_clk(ref_clk), .rst(rst), .conv_in(conv_in), .pins_in(pins_in),
    .ready_signal_format(ready_signal_format), .ch_enable(ch_enable),
    .data_ready_n_pin(data_ready_n_pin), .dout(dout), .dout_oe(dout_oe),
    .data_ready_flag(data_ready_flag), .conv_restart(conv_restart)
);

/* File: tb/arbr_host_model.sv */
// Purpose : host model reading frames and strobing resync
// Assumes : sclk idles high, device shifts on its falling edge
// Notes   : sclk runs only inside a frame, 8 clocks a period
module arbr_host_model (
    input  wire logic           ref_clk,
    output arbr_pkg::arbr_pins_t pins,
    input  wire logic           dout
);
    timeunit 1ns;
    timeprecision 1ns;
    import arbr_pkg::*;
    initial pins = '{sclk: 1'b1, cs_n: 1'b1, sync_reset_n: 1'b1};
    ////////////////////////////////////////
    // one frame; stop above 0 lifts cs_n early so nothing counts as read
    task automatic read_frame(input int nbits, input int stop,
                              output logic [47:0] q);
        int n;
        n = (stop > 0) ? stop : nbits;
        q = '0;
        @(posedge ref_clk) pins.cs_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            q = {q[46:0], dout};          // read before this edge lands
            pins.sclk <= 1'b0;
            repeat (4) @(posedge ref_clk);
            pins.sclk <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
        repeat (2) @(posedge ref_clk);
        pins.cs_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : read_frame
    // strobe long enough to pass the two flop synchroniser
    task automatic resync();
        @(posedge ref_clk) pins.sync_reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        pins.sync_reset_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : resync
endmodule : arbr_host_model

/* File: tb/arbr_ready_logic_tb.sv */
// Purpose : self checking bench of the result buffer ready logic
// Assumes : default blip and pulse lengths, both channels enabled except inside t_abort
// Notes   : frames carry enabled channels ascending, msb first
module arbr_ready_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import arbr_pkg::*;
    logic        ref_clk, rst, fmt, pin_n, dout, dout_oe, flag, restart;
    logic        pin_d;
    logic [1:0]  ch_en;
    logic [47:0] q;
    arbr_conv_t  conv_in;
    arbr_pins_t  pins;
    int          error_cnt, compares, falls, restarts;
    arbr_ready_logic DUT (
        .ref_clk(ref_clk), .rst(rst), .conv_in(conv_in), .pins_in(pins),
        .ready_signal_format(fmt), .ch_enable(ch_en),
        .data_ready_n_pin(pin_n), .dout(dout), .dout_oe(dout_oe),
        .data_ready_flag(flag), .conv_restart(restart));
    arbr_host_model HOST (.ref_clk(ref_clk), .pins(pins), .dout(dout));
    ////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // edge counters on the ready pin and restart strobe
    always @(posedge ref_clk) begin
        pin_d <= pin_n;
        if (pin_d === 1'b1 && pin_n === 1'b0) falls <= falls + 1;
        if (restart === 1'b1) restarts <= restarts + 1;
    end
    task automatic check(input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (exp !== got) begin
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
            error_cnt++;
        end
    endtask : check
    task automatic stop_test();
        $display("checks=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // distinct words per channel so order faults show
    function automatic logic [47:0] pat(input int k);
        return {12'(k), 12'h0a5, 12'(k), 12'h5a0};
    endfunction : pat
    function automatic logic [47:0] fr(input logic [47:0] d);
        return {d[23:0], d[47:24]};
    endfunction : fr
    // one conversion, then room for any pulse or blip to finish
    task automatic conv(input int k);
        @(posedge ref_clk);
        conv_in <= {1'b1, pat(k)};
        @(posedge ref_clk);
        conv_in.done <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask : conv
    task automatic rd(input logic [47:0] exp);
        HOST.read_frame(48, 0, q);
        check(fr(exp), q);
    endtask : rd
    ////////////////////////////////////////
    task automatic t_read_each();
        conv(1);
        check(1, flag);
        check(0, pin_n);
        rd(pat(1));
        check(0, flag);
        check(1, pin_n);
        rd(pat(1));
    endtask : t_read_each
    task automatic t_miss_one();
        conv(2);
        conv(3);
        check(0, pin_n);
        rd(pat(2));
        check(1, flag);
        rd(pat(3));
        check(0, flag);
    endtask : t_miss_one
    task automatic t_miss_two();
        conv(4);
        conv(5);
        conv(6);
        rd(pat(6));
        check(0, flag);
    endtask : t_miss_two
    // single channel frame, first cut short
    task automatic t_abort();
        ch_en <= 2'b10;
        conv(7);
        HOST.read_frame(24, 10, q);
        check(1, flag);
        HOST.read_frame(24, 0, q);
        check(pat(7) >> 24, q);
        check(0, flag);
        ch_en <= 2'b01;
        conv(14);
        HOST.read_frame(24, 0, q);
        check(pat(14) & 48'h0000_00ff_ffff, q);
        check(0, flag);
        ch_en <= 2'b11;
    endtask : t_abort
    task automatic t_resync();
        int r0;
        r0 = restarts;
        conv(8);
        HOST.resync();
        check(1, 48'(restarts - r0));
        check(0, flag);
        check(1, pin_n);
        conv(9);
        rd(pat(9));
    endtask : t_resync
    // no reads: pulses on every second conversion only
    task automatic t_pulse();
        int f0;
        fmt <= ARBR_FMT_PULSE;
        f0 = falls;
        for (int k = 10; k < 14; k++) conv(k);
        check(2, 48'(falls - f0));
        rd(pat(12));
        rd(pat(13));
        check(0, flag);
    endtask : t_pulse
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        conv_in = '0;
        fmt = ARBR_FMT_LEVEL;
        ch_en = 2'b11;
        {error_cnt, compares, falls, restarts} = '0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_read_each();
        t_miss_one();
        t_miss_two();
        t_abort();
        t_resync();
        t_pulse();
        stop_test();
    end
    // hang guard, far beyond the whole sequence
    initial begin
        #2_000_000;
        error_cnt++;
        stop_test();
    end
endmodule : arbr_ready_logic_tb
